// ===== hw/async_serial_baud_core.sv
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "serial_core_cfg.svh"

// Notes on behaviour
// - zero divisor stops the baud generator
// - divisor high five bits, low eight bits
// - high byte buffered, applied on low write
// - nonzero low reset, idle until enable written
// - one shared generator for transmit and receive
// - stop mode halts the baud generator, bus stays live
// - double buffered paths, separate enables
// - full duplex nrz on separate lines
// - eight or nine data bits selectable
// - hardware parity generate and check
// - receiver sleep, wake by idle or address
// - empty, complete, full flags for polling
// - overrun, parity, framing, noise, idle flags
// - three samples per bit, noise detect
// - eight byte wide software registers
// - loopback routes transmitter into receiver
// - start, data lsb first, optional ninth, stop
// - msb carries parity, odd select one
module async_serial_baud_core (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave port
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // system power state
    input wire logic stop_mode,
    // serial line
    input wire logic rxd_pin,
    output logic txd_pin
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // parity bit for the data bits below the msb
    function automatic logic par_bit(input logic [8:0] d, input logic nine, input logic odd);
        par_bit = (nine ? (^d[7:0]) : (^d[6:0])) ^ odd;
    endfunction

    // majority of three samples
    function automatic logic vote3(input logic a, input logic b, input logic c);
        vote3 = (a & b) | (a & c) | (b & c);
    endfunction

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    logic wr_pend_reg; // write data phase pending
    logic [31:0] wr_addr_reg; // address of that write
    logic [7:0] rd_value; // read mux output
    wire acc = hsel && htrans[`HTRANS_ACTIVE] && hready;
    wire rd_acc = acc && !hwrite;
    wire [7:0] wb = hwdata[7:0];
    wire wr_bdh = wr_pend_reg && (wr_addr_reg == `OFF_BAUD_HIGH);
    wire wr_bdl = wr_pend_reg && (wr_addr_reg == `OFF_BAUD_LOW);
    wire wr_c1 = wr_pend_reg && (wr_addr_reg == `OFF_CTRL_ONE);
    wire wr_c2 = wr_pend_reg && (wr_addr_reg == `OFF_CTRL_TWO);
    wire wr_c3 = wr_pend_reg && (wr_addr_reg == `OFF_CTRL_THREE);
    wire wr_data = wr_pend_reg && (wr_addr_reg == `OFF_DATA);
    wire rd_stat = rd_acc && (haddr == `OFF_STATUS_ONE);
    wire rd_data = rd_acc && (haddr == `OFF_DATA);

    // capture the address phase of writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 32'h0000_0000;
        end else if (hready) begin
            wr_pend_reg <= acc && hwrite;
            wr_addr_reg <= haddr;
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    logic [4:0] bdh_buf_reg; // buffered upper divisor bits
    logic [12:0] div_reg; // working divisor
    logic [7:0] c1_reg; // loop, nine bit, wake, idle type, parity
    logic [7:0] c2_reg; // enables and sleep
    logic t8_reg; // ninth transmit bit
    logic armed_reg; // generator released once an enable was written
    logic sleep_clr; // hardware wakeup
    wire nine = c1_reg[`C1_NINE];
    wire tx_on = c2_reg[`C2_TX_ON];
    wire rx_on = c2_reg[`C2_RX_ON];
    wire [3:0] nbits = nine ? `BITS_9 : `BITS_8;

    // divisor pair: low write commits both halves
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bdh_buf_reg <= `BAUD_HIGH_RST;
            div_reg <= `DIV_RST;
        end else if (wr_bdh) begin
            bdh_buf_reg <= wb[4:0];
        end else if (wr_bdl) begin
            div_reg <= {bdh_buf_reg, wb};
        end
    end

    // control bytes; sleep also cleared by hardware
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            c1_reg <= `CTRL_RST;
            c2_reg <= `CTRL_RST;
            t8_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            if (wr_c1)
                c1_reg <= wb;
            if (wr_c2)
                c2_reg <= wb;
            else if (sleep_clr)
                c2_reg[`C2_SLEEP] <= 1'b0;
            if (wr_c3)
                t8_reg <= wb[`C3_T8];
            // reset divisor is nonzero, so wait for a first enable write
            if (wr_c2 && (wb[`C2_TX_ON] || wb[`C2_RX_ON]))
                armed_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // baud generator, shared by both paths
    // ----------------------------------------
    logic tick; // sixteen per bit
    wire baud_run = armed_reg && !stop_mode;

    baud_tick_gen u_baud (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(baud_run),
        .divisor(div_reg),
        .tick(tick)
    );

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    logic tx_holding_empty_flag_reg, tc_reg, rdrf_reg, idle_reg, or_reg, nf_reg, fe_reg, pf_reg;
    logic stat_seen_reg; // status read armed the rx clear
    logic [8:0] rx_buf_reg; // receive holding register
    logic [7:0] tx_hold_reg; // transmit holding register
    logic load_now, tx_end, frame_done, accept, idle_event;
    logic frame_fe, frame_nf, frame_pf;
    logic [8:0] rx_data9;
    wire clr_rx = rd_data && stat_seen_reg;
    wire load_rx = accept && !rdrf_reg;
    wire ovr_rx = accept && rdrf_reg;

    // set always beats clear on the same edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_holding_empty_flag_reg <= 1'b1;
            tc_reg <= 1'b1;
            {rdrf_reg, idle_reg, or_reg, nf_reg, fe_reg, pf_reg} <= 6'h00;
            stat_seen_reg <= 1'b0;
            rx_buf_reg <= 9'h000;
            tx_hold_reg <= 8'h00;
        end else begin
            tx_holding_empty_flag_reg <= load_now || (tx_holding_empty_flag_reg && !wr_data);
            tc_reg <= (tx_end && tx_holding_empty_flag_reg) || (tc_reg && !wr_data);
            rdrf_reg <= load_rx || (rdrf_reg && !clr_rx);
            idle_reg <= idle_event || (idle_reg && !clr_rx);
            or_reg <= ovr_rx || (or_reg && !clr_rx);
            nf_reg <= (load_rx && frame_nf) || (nf_reg && !clr_rx);
            fe_reg <= (load_rx && frame_fe) || (fe_reg && !clr_rx);
            pf_reg <= (load_rx && frame_pf) || (pf_reg && !clr_rx);
            stat_seen_reg <= rd_stat || (stat_seen_reg && !rd_data);
            if (load_rx)
                rx_buf_reg <= rx_data9;
            if (wr_data)
                tx_hold_reg <= wb;
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always_comb begin
        if (haddr == `OFF_BAUD_HIGH)
            rd_value = {3'h0, bdh_buf_reg};
        else if (haddr == `OFF_BAUD_LOW)
            rd_value = div_reg[7:0];
        else if (haddr == `OFF_CTRL_ONE)
            rd_value = c1_reg;
        else if (haddr == `OFF_CTRL_TWO)
            rd_value = c2_reg;
        else if (haddr == `OFF_STATUS_ONE)
            rd_value = {tx_holding_empty_flag_reg, tc_reg, rdrf_reg, idle_reg, or_reg, nf_reg, fe_reg, pf_reg};
        else if (haddr == `OFF_CTRL_THREE)
            rd_value = {rx_buf_reg[8], t8_reg, 6'h00};
        else if (haddr == `OFF_DATA)
            rd_value = rx_buf_reg[7:0];
        else
            rd_value = 8'h00; // second status and unmapped read zero
    end

    // zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (rd_acc) begin
            hrdata <= {24'h00_0000, rd_value};
        end
    end

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    serial_core_pkg::tx_state_e tx_state_reg;
    logic [3:0] tx_phase_reg, tx_count_reg;
    logic [10:0] tx_shift_reg; // stop, data, start; lsb leaves first
    logic [8:0] tx_d9;
    logic [8:0] tx_dp;
    logic [10:0] tx_frame;
    assign tx_d9 = {t8_reg, tx_hold_reg};
    // parity replaces the msb of the character
    always_comb begin
        tx_dp = tx_d9;
        if (c1_reg[`C1_PAR_ON] && nine)
            tx_dp[8] = par_bit(tx_d9, nine, c1_reg[`C1_PAR_ODD]);
        else if (c1_reg[`C1_PAR_ON])
            tx_dp[7] = par_bit(tx_d9, nine, c1_reg[`C1_PAR_ODD]);
    end
    assign tx_frame = nine ? {1'b1, tx_dp, 1'b0} : {2'b11, tx_dp[7:0], 1'b0};
    assign load_now = tick && (tx_state_reg == serial_core_pkg::TX_IDLE) && tx_on && !tx_holding_empty_flag_reg;
    assign tx_end = tick && (tx_state_reg == serial_core_pkg::TX_SHIFT)
        && (tx_phase_reg == `OVS_LAST) && (tx_count_reg == nbits + `FRAME_EXTRA - 4'h1);

    // one bit per sixteen ticks, holding register frees at load
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_state_reg <= serial_core_pkg::TX_IDLE;
            tx_phase_reg <= 4'h0;
            tx_count_reg <= 4'h0;
            tx_shift_reg <= 11'h7ff;
        end else begin
            case (tx_state_reg)
                serial_core_pkg::TX_IDLE: begin
                    if (load_now) begin
                        tx_shift_reg <= tx_frame;
                        tx_phase_reg <= 4'h0;
                        tx_count_reg <= 4'h0;
                        tx_state_reg <= serial_core_pkg::TX_SHIFT;
                    end
                end
                default: begin
                    if (tick) begin
                        tx_phase_reg <= tx_phase_reg + 4'h1;
                        if (tx_end) begin
                            tx_state_reg <= serial_core_pkg::TX_IDLE;
                        end else if (tx_phase_reg == `OVS_LAST) begin
                            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                            tx_count_reg <= tx_count_reg + 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // line idles high, nrz level of the current bit otherwise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            txd_pin <= 1'b1;
        else
            txd_pin <= (tx_state_reg == serial_core_pkg::TX_SHIFT) ? tx_shift_reg[0] : 1'b1;
    end

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    serial_core_pkg::rx_state_e rx_state_reg;
    logic rx_s1_reg, rx_s2_reg; // pin synchroniser
    logic rx_prev_reg, samp_a_reg, samp_b_reg, rx_noise_reg, idle_armed_reg;
    logic [3:0] rx_phase_reg, rx_bits_reg, idle_ticks_reg, idle_bits_reg;
    logic [8:0] rx_shift_reg;

    // loopback ignores the pin entirely
    wire rx_line = c1_reg[`C1_LOOP] ? txd_pin : rx_s2_reg;
    wire rx_vote = tick && (rx_phase_reg == `VOTE_C);
    wire bit_val = vote3(samp_a_reg, samp_b_reg, rx_line);
    wire noisy = !((samp_a_reg == samp_b_reg) && (samp_b_reg == rx_line));
    wire rx_msb = nine ? rx_data9[8] : rx_data9[7];
    wire sleeping = c2_reg[`C2_SLEEP];
    wire addr_wake = c1_reg[`C1_WAKE] && rx_msb;
    wire idle_hit = tick && (rx_state_reg == serial_core_pkg::RX_IDLE) && rx_line
        && (idle_ticks_reg == `OVS_LAST) && (idle_bits_reg == nbits + `FRAME_EXTRA - 4'h1);
    assign rx_data9 = nine ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
    assign frame_done = (rx_state_reg == serial_core_pkg::RX_STOP) && rx_vote;
    assign accept = frame_done && (!sleeping || addr_wake);
    assign frame_fe = !bit_val;
    assign frame_nf = rx_noise_reg || noisy;
    assign frame_pf = c1_reg[`C1_PAR_ON] && (par_bit(rx_data9, nine, c1_reg[`C1_PAR_ODD]) != rx_msb);
    assign idle_event = idle_hit && idle_armed_reg && !sleeping;
    assign sleep_clr = sleeping && ((frame_done && addr_wake)
        || (idle_hit && !c1_reg[`C1_WAKE]));

    // two flops before any use of the pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
        end else begin
            rx_s1_reg <= rxd_pin;
            rx_s2_reg <= rx_s1_reg;
        end
    end

    // idle line counter, in bit times of high level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_ticks_reg <= 4'h0;
            idle_bits_reg <= 4'h0;
            idle_armed_reg <= 1'b0;
        end else if (frame_done) begin
            idle_ticks_reg <= 4'h0;
            // type zero also counts the stop bit already seen
            idle_bits_reg <= c1_reg[`C1_ILT] ? 4'h0 : `IDLE_PRELOAD;
            idle_armed_reg <= 1'b1;
        end else if (tick && (rx_state_reg == serial_core_pkg::RX_IDLE)) begin
            if (!rx_line) begin
                idle_ticks_reg <= 4'h0;
                idle_bits_reg <= 4'h0;
            end else if (idle_hit) begin
                idle_bits_reg <= 4'h0;
                idle_ticks_reg <= 4'h0;
                idle_armed_reg <= 1'b0; // one flag per idle period
            end else begin
                idle_ticks_reg <= idle_ticks_reg + 4'h1;
                if (idle_ticks_reg == `OVS_LAST)
                    idle_bits_reg <= idle_bits_reg + 4'h1;
            end
        end
    end

    // start search, three votes per bit at ticks seven to nine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_state_reg <= serial_core_pkg::RX_IDLE;
            {rx_prev_reg, samp_a_reg, samp_b_reg, rx_noise_reg} <= 4'hf;
            rx_phase_reg <= 4'h0;
            rx_bits_reg <= 4'h0;
            rx_shift_reg <= 9'h000;
        end else if (!rx_on) begin
            rx_state_reg <= serial_core_pkg::RX_IDLE; // separate enable
        end else if (tick) begin
            rx_prev_reg <= rx_line;
            rx_phase_reg <= rx_phase_reg + 4'h1;
            if (rx_phase_reg == `VOTE_A)
                samp_a_reg <= rx_line;
            if (rx_phase_reg == `VOTE_B)
                samp_b_reg <= rx_line;
            case (rx_state_reg)
                serial_core_pkg::RX_IDLE: begin
                    if (rx_prev_reg && !rx_line) begin
                        rx_state_reg <= serial_core_pkg::RX_START;
                        rx_phase_reg <= 4'h1;
                        rx_noise_reg <= 1'b0;
                    end
                end
                serial_core_pkg::RX_START: begin
                    if (rx_vote && bit_val)
                        rx_state_reg <= serial_core_pkg::RX_IDLE; // glitch, not a start
                    else if (rx_vote)
                        rx_noise_reg <= noisy;
                    if (rx_phase_reg == `OVS_LAST) begin
                        rx_state_reg <= serial_core_pkg::RX_DATA;
                        rx_bits_reg <= 4'h0;
                    end
                end
                serial_core_pkg::RX_DATA: begin
                    if (rx_vote) begin
                        rx_shift_reg <= {bit_val, rx_shift_reg[8:1]}; // lsb first
                        rx_bits_reg <= rx_bits_reg + 4'h1;
                        rx_noise_reg <= rx_noise_reg || noisy;
                    end
                    if ((rx_phase_reg == `OVS_LAST) && (rx_bits_reg == nbits))
                        rx_state_reg <= serial_core_pkg::RX_STOP;
                end
                default: begin
                    // finish at mid stop bit to allow resync on the next start
                    if (rx_vote)
                        rx_state_reg <= serial_core_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_low_write;
        wr_bdl && !wr_bdh;
    endsequence

    a_divisor_commit: assert property (s_low_write |=>
        div_reg == $past({bdh_buf_reg, hwdata[7:0]})) else $error("divisor not committed");
    a_high_buffered: assert property (wr_bdh |=> $stable(div_reg))
        else $error("divisor moved on high write");
    a_gen_unarmed: assert property (!armed_reg |=> !tick)
        else $error("baud tick before enable");
    a_stop_halts: assert property (stop_mode |=> !tick)
        else $error("baud tick in stop mode");
    a_start_bit: assert property (load_now |=> ##1 !txd_pin)
        else $error("no start bit after load");
    a_idle_high: assert property ($past(tx_state_reg) == serial_core_pkg::TX_IDLE |-> txd_pin)
        else $error("line low while idle");
    a_loop_route: assert property (c1_reg[`C1_LOOP] |-> rx_line == txd_pin)
        else $error("loopback not routed");
    a_tx_holding_empty_flag_clear: assert property (wr_data && !load_now |=> !tx_holding_empty_flag_reg)
        else $error("empty flag kept after data write");
    a_overrun_keep: assert property (ovr_rx |=> or_reg && $stable(rx_buf_reg))
        else $error("overrun lost or buffer overwritten");
endmodule

// ===== inc/serial_core_cfg.svh
`ifndef SERIAL_CORE_CFG_SVH
`define SERIAL_CORE_CFG_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define OFF_BAUD_HIGH 32'h0000_0000
`define OFF_BAUD_LOW 32'h0000_0004
`define OFF_CTRL_ONE 32'h0000_0008
`define OFF_CTRL_TWO 32'h0000_000c
`define OFF_STATUS_ONE 32'h0000_0010
`define OFF_STATUS_TWO 32'h0000_0014
`define OFF_CTRL_THREE 32'h0000_0018
`define OFF_DATA 32'h0000_001c

// ----------------------------------------
// reset values
// ----------------------------------------
`define BAUD_HIGH_RST 5'h00
`define DIV_RST 13'h0004
`define CTRL_RST 8'h00
`define DIV_ZERO 13'h0000

// ----------------------------------------
// field positions
// ----------------------------------------
`define C1_LOOP 7
`define C1_NINE 4
`define C1_WAKE 3
`define C1_ILT 2
`define C1_PAR_ON 1
`define C1_PAR_ODD 0
`define C2_TX_ON 3
`define C2_RX_ON 2
`define C2_SLEEP 1
`define C3_T8 6
`define HTRANS_ACTIVE 1

// ----------------------------------------
// bit timing: sample points in oversampling ticks, frame lengths in bits
// ----------------------------------------
`define OVS_LAST 4'hf
`define VOTE_A 4'h7
`define VOTE_B 4'h8
`define VOTE_C 4'h9
`define BITS_8 4'h8
`define BITS_9 4'h9
`define FRAME_EXTRA 4'h2
`define IDLE_PRELOAD 4'h1

`endif

// ===== inc/serial_core_pkg.sv
package serial_core_pkg;
    // transmitter sequencer
    typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;
    // receiver sequencer
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
endpackage

// ===== hw/baud_tick_gen.sv
`timescale 1ns/1ps
`include "serial_core_cfg.svh"

// modulo divider: one tick every divisor clocks, sixteen ticks per bit
module baud_tick_gen (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic run,
    input wire logic [12:0] divisor,
    // oversampling tick
    output logic tick
);
    logic [12:0] cnt_reg; // position inside one tick period

    // zero divisor or no run keeps the counter frozen: no toggling at all
    wire active = run && (divisor != `DIV_ZERO);
    wire wrap = (cnt_reg >= divisor - 13'h0001);

    // ----------------------------------------
    // counter and tick
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= `DIV_ZERO;
            tick <= 1'b0;
        end else if (!active) begin
            tick <= 1'b0; // hold, keeps old count for a clean restart
        end else if (wrap) begin
            cnt_reg <= `DIV_ZERO;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 13'h0001;
            tick <= 1'b0;
        end
    end

    a_tick_off_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (divisor == `DIV_ZERO) |=> !tick) else $error("tick while divisor zero");
endmodule

// ===== verification/remote_port_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// far-end serial port
// ----------------------------------------
module remote_port_model #(
    parameter int BIT_CLKS = 16
) (
    // clock
    input wire logic hclk,
    // serial lines
    input wire logic txd,
    output logic rxd
);
    // idle line is high between frames
    initial rxd = 1'b1;

    // start, eight data lsb first, stop
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        @(posedge hclk);
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (BIT_CLKS) @(posedge hclk);
        end
    endtask

    // mid-bit sampling, so a wrong bit time slips the byte
    task automatic catch(output logic [7:0] b, output logic stop_ok);
        @(negedge txd);
        repeat (BIT_CLKS / 2) @(posedge hclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge hclk);
            b[i] = txd;
        end
        repeat (BIT_CLKS) @(posedge hclk);
        stop_ok = txd;
    endtask
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`include "serial_core_cfg.svh"

module tb_top;
    // bench signals
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp, rxd, txd;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
    logic [7:0] b;
    logic stop = 1'b0; // system stop request, driven so the halt can be seen
    logic s;
    int err_count = 0, checked = 0;

    // ----------------------------------------
    // design and far end
    // ----------------------------------------
    async_serial_baud_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .stop_mode(stop),
        .rxd_pin(rxd), .txd_pin(txd));
    remote_port_model #(.BIT_CLKS(16)) u_far (.hclk(hclk), .txd(txd), .rxd(rxd));

    initial begin
        forever #2.5 hclk = ~hclk;
    end

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // one single transfer; ready is waited for, never assumed
    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hready !== 1'b1);
        v = hrdata;
        chk("hresp", hresp, 1'b0);
    endtask

    // poll until a character is held, then fetch it
    task automatic wait_rx(input logic [7:0] exp);
        v = 32'h0;
        for (int i = 0; i < 400 && v[5] !== 1'b1; i++) bus(1'b0, `OFF_STATUS_ONE, 8'h0);
        bus(1'b0, `OFF_DATA, 8'h0);
        chk("rx data", v, {24'h0, exp});
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic t_reset;
        bus(1'b0, `OFF_BAUD_LOW, 8'h0);
        chk("baud low", v, 32'h4);
        bus(1'b0, `OFF_STATUS_ONE, 8'h0);
        chk("status", v, 32'hc0);
        bus(1'b0, 32'h40, 8'h0);
        chk("unmapped", v, 32'h0);
        bus(1'b1, `OFF_BAUD_HIGH, 8'hff);
        bus(1'b0, `OFF_BAUD_HIGH, 8'h0);
        chk("baud high", v, 32'h1f);
        $display("test reset done");
    endtask

    // zero divisor stalls, the low write commits and the frame leaves
    task automatic t_tx;
        bus(1'b1, `OFF_BAUD_HIGH, 8'h0);
        bus(1'b1, `OFF_BAUD_LOW, 8'h0);
        bus(1'b1, `OFF_CTRL_TWO, 8'h0c);
        bus(1'b1, `OFF_DATA, 8'ha5);
        repeat (200) @(posedge hclk);
        chk("txd held", txd, 1'b1);
        fork
            u_far.catch(b, s);
            bus(1'b1, `OFF_BAUD_LOW, 8'h1);
        join
        chk("tx byte", b, 8'ha5);
        chk("tx stop", s, 1'b1);
        $display("test tx done");
    endtask

    task automatic t_rx;
        u_far.send(8'h3c);
        wait_rx(8'h3c);
        $display("test rx done");
    endtask

    // stop freezes the generator; the held byte only leaves on release
    task automatic t_stop;
        @(posedge hclk) stop <= 1'b1;
        bus(1'b1, `OFF_DATA, 8'hc3);
        repeat (100) @(posedge hclk);
        chk("stop txd", txd, 1'b1);
        bus(1'b0, `OFF_STATUS_ONE, 8'h0);
        chk("stop status", v[7:6], 2'b00);
        fork
            u_far.catch(b, s);
            @(posedge hclk) stop <= 1'b0;
        join
        chk("stop byte", b, 8'hc3);
        $display("test stop done");
    endtask

    // even then odd parity in the msb
    task automatic t_par;
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, `OFF_CTRL_ONE, 8'h02 | i[7:0]);
            fork
                u_far.catch(b, s);
                bus(1'b1, `OFF_DATA, 8'h03);
            join
            chk("parity", b, i ? 8'h83 : 8'h03);
        end
        $display("test parity done");
    endtask

    task automatic t_loop;
        bus(1'b1, `OFF_CTRL_ONE, 8'h80);
        bus(1'b1, `OFF_DATA, 8'h5a);
        wait_rx(8'h5a);
        // nine bit character, ninth bit comes back in control three
        bus(1'b1, `OFF_CTRL_ONE, 8'h90);
        bus(1'b1, `OFF_CTRL_THREE, 8'h40);
        bus(1'b1, `OFF_DATA, 8'h96);
        wait_rx(8'h96);
        bus(1'b0, `OFF_CTRL_THREE, 8'h0);
        chk("ninth bit", v, 32'hc0);
        // second char lands on an unread one: overrun, old byte kept
        bus(1'b1, `OFF_DATA, 8'h11);
        bus(1'b1, `OFF_DATA, 8'h22);
        repeat (450) @(posedge hclk);
        bus(1'b0, `OFF_STATUS_ONE, 8'h0);
        chk("overrun", v & 32'h2f, 32'h28);
        bus(1'b0, `OFF_DATA, 8'h0);
        chk("kept byte", v, 32'h11);
        $display("test loop done");
    endtask

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_tx();
        t_rx();
        t_stop();
        t_par();
        t_loop();
        close_out();
    end

    initial begin
        repeat (30000) @(posedge hclk);
        err_count++;
        close_out();
    end
endmodule
